// ---- design/scr_deglitch.sv ----
// Deglitch filter: output goes high only after input holds high for a full period.
// Assumes the input is synchronous to mclk.
`timescale 1ns/10ps
module scr_deglitch (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Raw and filtered level
    input wire logic rawIn,
    output logic filtOut
);
    import scr_pkg::*;

    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic done;

    assign done = (cnt_reg == 8'(SCR_DEGLITCH_CYC));
    assign cnt_next = !rawIn ? 8'h00 : (done ? cnt_reg : cnt_reg + 8'h01);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 8'h00;
            filtOut <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            filtOut <= rawIn && done;
        end
    end
endmodule

// ---- design/scr_i2c_regs.sv ----
// Serial slave with two byte registers: diagnostic flags and output control.
// Assumes external pull-ups on both serial lines and comparator levels on mclk.
`timescale 1ns/10ps

module scr_i2c_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial clock and data pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Chip address selection and supply lockout
    input wire logic [1:0] addrSel,
    input wire logic uvloActive,
    // Analog comparator levels
    input wire scr_pkg::scr_analog_t analogIn,
    // Converter settings
    output scr_pkg::scr_ctrl_out_t ctrlOut,
    // Flags for the rest of the chip
    output logic standby
);
    import scr_pkg::*;

    // ****************************************************************
    // States
    // ****************************************************************
    typedef enum logic [2:0] {
        SCR_IDLE,
        SCR_RX_BYTE,
        SCR_ACK,
        SCR_TX_BYTE,
        SCR_TX_ACK
    } scr_state_t;

    typedef enum logic [1:0] {
        SCR_PH_CHIP,
        SCR_PH_REG,
        SCR_PH_DATA
    } scr_phase_t;

    // ****************************************************************
    // Pin conditioning
    // ****************************************************************
    logic sclLvl;
    logic sclRise;
    logic sclFall;
    logic sdaLvl;
    logic sdaRise;
    logic sdaFall;
    logic pdFilt;

    scr_pin_sync u_scl (
        .mclk(mclk),
        .rst(rst),
        .pinIn(sclIn),
        .level(sclLvl),
        .rise(sclRise),
        .fall(sclFall)
    );

    scr_pin_sync u_sda (
        .mclk(mclk),
        .rst(rst),
        .pinIn(sdaIn),
        .level(sdaLvl),
        .rise(sdaRise),
        .fall(sdaFall)
    );

    scr_deglitch u_pd (
        .mclk(mclk),
        .rst(rst),
        .rawIn(analogIn.pulldownOver),
        .filtOut(pdFilt)
    );

    // ****************************************************************
    // Registers and next values
    // ****************************************************************
    scr_state_t state_reg;
    scr_state_t state_next;
    scr_phase_t phase_reg;
    scr_phase_t phase_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [3:0] bitCnt_reg;
    logic [3:0] bitCnt_next;
    logic [7:0] regPtr_reg;
    logic [7:0] regPtr_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic readMode_reg;
    logic readMode_next;
    logic ackThis_reg;
    logic ackThis_next;
    logic sdaOe_next;

    // ****************************************************************
    // Decoding
    // ****************************************************************
    function automatic logic [7:0] scr_read_mux(input logic [7:0] ptr,
                                                input logic [7:0] flagsV,
                                                input logic [7:0] ctrlV);
        scr_read_mux = (ptr[0] == SCR_ADDR_CTRL[0]) ? ctrlV : flagsV;
    endfunction

    logic startCond;
    logic stopCond;
    logic byteDone;
    logic [7:0] rxByte;
    logic chipMatch;
    logic ackWanted;
    logic writeCtrl;
    logic [7:0] txByte;
    logic [7:0] nextPtr;

    assign startCond = sdaFall && sclLvl;
    assign stopCond = sdaRise && sclLvl;
    assign rxByte = {shift_reg[6:0], sdaLvl};
    assign byteDone = (bitCnt_reg == SCR_BITS_PER_BYTE - 4'h1);
    assign chipMatch = (rxByte[7:1] == {SCR_CHIP_BASE, addrSel});
    assign ackWanted = !uvloActive &&
        ((phase_reg != SCR_PH_CHIP) || chipMatch);
    assign writeCtrl = (phase_reg == SCR_PH_DATA) && (regPtr_reg == SCR_ADDR_CTRL);
    assign nextPtr = {7'h00, ~regPtr_reg[0]};
    assign txByte = scr_read_mux(regPtr_reg, flags_reg, ctrl_reg);

    // Flags track the comparators; reserved bits stay zero
    always_comb begin
        flags_next = SCR_FLAGS_RESET;
        flags_next[SCR_OVERLOAD_BIT] = analogIn.overload;
        flags_next[SCR_OVERTEMP_BIT] = analogIn.overtemp;
        flags_next[SCR_OUTLOW_BIT] = analogIn.outputLow;
        flags_next[SCR_INLOW_BIT] = analogIn.inputLow;
        flags_next[SCR_PULLDOWN_BIT] = pdFilt;
    end

    // ****************************************************************
    // Protocol state machine
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        shift_next = shift_reg;
        bitCnt_next = bitCnt_reg;
        regPtr_next = regPtr_reg;
        ctrl_next = ctrl_reg;
        readMode_next = readMode_reg;
        ackThis_next = ackThis_reg;
        sdaOe_next = sdaOe;
        if (startCond) begin
            state_next = SCR_RX_BYTE;
            phase_next = SCR_PH_CHIP;
            bitCnt_next = 4'h0;
            sdaOe_next = 1'b0;
        end else if (stopCond) begin
            state_next = SCR_IDLE;
            sdaOe_next = 1'b0;
        end else begin
            unique case (state_reg)
                SCR_IDLE: begin
                    sdaOe_next = 1'b0;
                end
                SCR_RX_BYTE: begin
                    if (sclRise) begin
                        shift_next = rxByte;
                        bitCnt_next = bitCnt_reg + 4'h1;
                        if (byteDone) begin
                            ackThis_next = ackWanted;
                            state_next = SCR_ACK;
                            unique case (phase_reg)
                                SCR_PH_CHIP: begin
                                    readMode_next = rxByte[0];
                                    phase_next = SCR_PH_REG;
                                end
                                SCR_PH_REG: begin
                                    regPtr_next = rxByte;
                                    phase_next = SCR_PH_DATA;
                                end
                                SCR_PH_DATA: begin
                                    if (writeCtrl) begin
                                        ctrl_next = rxByte;
                                    end
                                end
                            endcase
                        end
                    end
                end
                SCR_ACK: begin
                    if (sclFall) begin
                        if (sdaOe) begin
                            sdaOe_next = 1'b0;
                            bitCnt_next = 4'h0;
                            if (readMode_reg && phase_reg == SCR_PH_REG) begin
                                state_next = SCR_TX_BYTE;
                                shift_next = txByte;
                                sdaOe_next = !txByte[7];
                            end else begin
                                state_next = SCR_RX_BYTE;
                            end
                        end else if (ackThis_reg) begin
                            sdaOe_next = 1'b1;
                        end else begin
                            state_next = SCR_IDLE;
                        end
                    end
                end
                SCR_TX_BYTE: begin
                    if (sclFall) begin
                        bitCnt_next = bitCnt_reg + 4'h1;
                        shift_next = {shift_reg[6:0], 1'b0};
                        if (byteDone) begin
                            state_next = SCR_TX_ACK;
                            sdaOe_next = 1'b0;
                        end else begin
                            sdaOe_next = !shift_reg[6];
                        end
                    end
                end
                SCR_TX_ACK: begin
                    if (sclRise) begin
                        if (!sdaLvl) begin
                            regPtr_next = nextPtr;
                            ackThis_next = 1'b1;
                        end else begin
                            ackThis_next = 1'b0;
                        end
                    end else if (sclFall) begin
                        bitCnt_next = 4'h0;
                        if (ackThis_reg) begin
                            state_next = SCR_TX_BYTE;
                            shift_next = txByte;
                            sdaOe_next = !txByte[7];
                        end else begin
                            state_next = SCR_IDLE;
                        end
                    end
                end
                default: begin
                    state_next = SCR_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= SCR_IDLE;
            phase_reg <= SCR_PH_CHIP;
            shift_reg <= 8'h00;
            bitCnt_reg <= 4'h0;
            regPtr_reg <= SCR_ADDR_FLAGS;
            readMode_reg <= 1'b0;
            ackThis_reg <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            shift_reg <= shift_next;
            bitCnt_reg <= bitCnt_next;
            regPtr_reg <= regPtr_next;
            readMode_reg <= readMode_next;
            ackThis_reg <= ackThis_next;
            sdaOe <= sdaOe_next;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= SCR_CTRL_RESET;
            flags_reg <= SCR_FLAGS_RESET;
            ctrlOut <= '0;
            standby <= 1'b1;
            sdaOut <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            flags_reg <= flags_next;
            ctrlOut.levelCode <= ctrl_reg[SCR_LEVEL_MSB:SCR_LEVEL_LSB];
            ctrlOut.comp <= ctrl_reg[SCR_COMP_BIT];
            standby <= (ctrl_reg[SCR_LEVEL_MSB:SCR_LEVEL_LSB] == SCR_LEVEL_STANDBY);
            sdaOut <= 1'b0;
        end
    end
endmodule

// ---- design/scr_pin_sync.sv ----
// Two-stage synchroniser with edge detection on the second stage output.
// Assumes an asynchronous level input.
`timescale 1ns/10ps
module scr_pin_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Level in, synchronised level and edges out
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg && !prev_reg;
    assign fall = !sync_reg && prev_reg;
endmodule

// ---- inc/scr_pkg.sv ----
// Constants and carrier types for the supply control register interface.
// Assumes a single system clock of 25 MHz; the serial pins are sampled on it.
package scr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] SCR_ADDR_FLAGS = 8'h00;
    localparam logic [7:0] SCR_ADDR_CTRL = 8'h01;
    localparam logic [7:0] SCR_FLAGS_RESET = 8'h00;
    localparam logic [7:0] SCR_CTRL_RESET = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SCR_LEVEL_LSB = 0;
    localparam int SCR_LEVEL_MSB = 2;
    localparam int SCR_COMP_BIT = 3;
    localparam int SCR_OVERLOAD_BIT = 0;
    localparam int SCR_OVERTEMP_BIT = 1;
    localparam int SCR_OUTLOW_BIT = 2;
    localparam int SCR_INLOW_BIT = 3;
    localparam int SCR_PULLDOWN_BIT = 4;
    localparam logic [2:0] SCR_LEVEL_STANDBY = 3'h0;

    // ****************************************************************
    // Chip address and timing
    // ****************************************************************
    localparam logic [4:0] SCR_CHIP_BASE = 5'h04;
    localparam logic [3:0] SCR_BITS_PER_BYTE = 4'h8;
    localparam int SCR_CLK_MHZ = 25;
    localparam int SCR_DEGLITCH_NS = 1000;
    localparam int SCR_DEGLITCH_CYC = (SCR_DEGLITCH_NS * SCR_CLK_MHZ + 999) / 1000;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic pulldownOver;
        logic inputLow;
        logic outputLow;
        logic overtemp;
        logic overload;
    } scr_analog_t;

    typedef struct packed {
        logic comp;
        logic [2:0] levelCode;
    } scr_ctrl_out_t;

endpackage

// ---- tb/scr_i2c_regs_chk.sv ----
// Port checker for the supply control register block.
// Assumes one mclk domain and the asynchronous active high reset.
`timescale 1ns/10ps
module scr_i2c_regs_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial pins
    input wire logic sclIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Lockout and settings
    input wire logic uvloActive,
    input wire scr_pkg::scr_ctrl_out_t ctrlOut,
    input wire logic standby
);
    import scr_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_reset_clear;
        $fell(rst) |-> ctrlOut == 4'h0 && standby;
    endproperty
    property p_standby_code;
        $stable(ctrlOut) |-> standby == (ctrlOut.levelCode == SCR_LEVEL_STANDBY);
    endproperty
    property p_uvlo_quiet;
        uvloActive [*8] |-> !sdaOe;
    endproperty
    property p_oe_scl_low;
        $changed(sdaOe) |-> !sclIn;
    endproperty
    property p_ack_hold;
        $rose(sdaOe) |=> sdaOe [*8];
    endproperty
    property p_release_hold;
        $fell(sdaOe) |=> !sdaOe [*6];
    endproperty
    property p_open_drain;
        sdaOe |-> sdaOut == 1'b0;
    endproperty
    property p_ctrl_update;
        $changed(ctrlOut) |-> sclIn && !sdaOe;
    endproperty
    property p_ctrl_idle;
        sclIn [*8] ##1 sclIn |-> $stable(ctrlOut);
    endproperty

    // ****************************************************************
    // Assertions and covers
    // ****************************************************************
    a_reset_clear: assert property (p_reset_clear)
        else $error("settings not clear after reset");
    a_standby_code: assert property (p_standby_code)
        else $error("standby does not follow level code");
    a_uvlo_quiet: assert property (p_uvlo_quiet)
        else $error("data line driven during lockout");
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data drive changed while clock high");
    a_ack_hold: assert property (p_ack_hold)
        else $error("low drive released too early");
    a_release_hold: assert property (p_release_hold)
        else $error("data line grabbed again too soon");
    a_open_drain: assert property (p_open_drain)
        else $error("data line driven high");
    a_ctrl_update: assert property (p_ctrl_update)
        else $error("settings changed outside a data byte");
    a_ctrl_idle: assert property (p_ctrl_idle)
        else $error("settings changed on an idle bus");
    c_ack: cover property ($rose(sdaOe));
    c_ctrl: cover property ($changed(ctrlOut));
    c_uvlo: cover property (uvloActive [*8]);
endmodule

bind scr_i2c_regs scr_i2c_regs_chk chk_u (.mclk(mclk), .rst(rst), .sclIn(sclIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .uvloActive(uvloActive), .ctrlOut(ctrlOut),
    .standby(standby));

// ---- tb/scr_i2c_regs_tb.sv ----
// Self-checking bench for the supply control register block.
// Assumes the master model paces the serial pins and the checker is bound.
`timescale 1ns/10ps
module scr_i2c_regs_tb;
    import scr_pkg::*;
    typedef struct packed {
        logic [7:0] ra;
        logic [7:0] ctrl;
        scr_analog_t ana;
        logic [7:0] flags;
        logic stby;
    } scr_row_t;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] addrSel = 2'h0;
    logic uvloActive = 1'b0;
    scr_analog_t analogIn = 5'h00;
    logic sclIn, sdaIn, sdaOut, sdaOe, standby, ack;
    scr_ctrl_out_t ctrlOut;
    logic [7:0] b0, b1, e0, e1;
    int n_mismatch = 0;
    int samples_checked = 0;
    scr_row_t rows [8] = '{'{8'h00, 8'h00, 5'h01, 8'h01, 1'b1},
        '{8'h01, 8'h01, 5'h02, 8'h02, 1'b0}, '{8'h00, 8'h02, 5'h04, 8'h04, 1'b0},
        '{8'h01, 8'h03, 5'h08, 8'h08, 1'b0}, '{8'h00, 8'h05, 5'h10, 8'h10, 1'b0},
        '{8'h01, 8'h06, 5'h1f, 8'h1f, 1'b0}, '{8'h00, 8'h07, 5'h00, 8'h00, 1'b0},
        '{8'h01, 8'h0d, 5'h15, 8'h15, 1'b0}};

    initial forever #20 mclk = ~mclk;

    scr_i2c_regs dut_u (.mclk(mclk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel), .uvloActive(uvloActive),
        .analogIn(analogIn), .ctrlOut(ctrlOut), .standby(standby));
    scr_master mst_u (.mclk(mclk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic addrByte(input logic rd, input logic expAck);
        mst_u.start();
        mst_u.sendByte({SCR_CHIP_BASE, addrSel, rd}, ack);
        check("addrAck", {7'h0, expAck}, {7'h0, ack});
    endtask

    task automatic wrTx(input logic [7:0] ra, input logic [23:0] d, input int n);
        addrByte(1'b0, 1'b1);
        mst_u.sendByte(ra, ack);
        check("regAck", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            mst_u.sendByte(d[23 - 8 * i -: 8], ack);
            check("dataAck", 8'h01, {7'h0, ack});
        end
        mst_u.stop();
    endtask

    task automatic rdTx(input logic [7:0] ra, input logic [7:0] x0, input logic [7:0] x1);
        wrTx(ra, 24'h0, 0);
        addrByte(1'b1, 1'b1);
        mst_u.recvByte(1'b0, b0);
        mst_u.recvByte(1'b1, b1);
        mst_u.stop();
        check("firstByte", x0, b0);
        check("nextByte", x1, b1);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        idle(6);
        check("ctrlRst", 8'h00, {4'h0, ctrlOut});
        check("stbyRst", 8'h01, {7'h0, standby});
        rst = 1'b0;
        idle(4);
        rdTx(SCR_ADDR_FLAGS, SCR_FLAGS_RESET, SCR_CTRL_RESET);
        $display("test reset done");
        foreach (rows[i]) begin
            analogIn = rows[i].ana;
            wrTx(SCR_ADDR_CTRL, {rows[i].ctrl, 16'h0}, 1);
            check("ctrlOut", rows[i].ctrl, {4'h0, ctrlOut});
            check("standby", {7'h0, rows[i].stby}, {7'h0, standby});
            e0 = rows[i].ra[0] ? rows[i].ctrl : rows[i].flags;
            e1 = rows[i].ra[0] ? rows[i].flags : rows[i].ctrl;
            rdTx(rows[i].ra, e0, e1);
        end
        $display("test table done");
        analogIn = 5'h00;
        wrTx(SCR_ADDR_CTRL, 24'h03060a, 3);
        rdTx(SCR_ADDR_CTRL, 8'h0a, 8'h00);
        wrTx(SCR_ADDR_FLAGS, 24'hff0000, 1);
        wrTx(8'h02, 24'hff0000, 1);
        rdTx(SCR_ADDR_FLAGS, 8'h00, 8'h0a);
        $display("test writes done");
        addrSel = 2'h2;
        mst_u.start();
        mst_u.sendByte({SCR_CHIP_BASE, 2'h1, 1'b0}, ack);
        check("wrongAck", 8'h00, {7'h0, ack});
        mst_u.stop();
        rdTx(SCR_ADDR_CTRL, 8'h0a, 8'h00);
        uvloActive = 1'b1;
        idle(10);
        addrByte(1'b0, 1'b0);
        mst_u.stop();
        uvloActive = 1'b0;
        $display("test refuse done");
        analogIn = 5'h10;
        idle(SCR_DEGLITCH_CYC - 4);
        analogIn = 5'h00;
        rdTx(SCR_ADDR_FLAGS, 8'h00, 8'h0a);
        $display("test deglitch done");
        wrTx(SCR_ADDR_CTRL, 24'h0d0000, 1);
        rst = 1'b1;
        idle(3);
        check("ctrlRst2", 8'h00, {4'h0, ctrlOut});
        check("stbyRst2", 8'h01, {7'h0, standby});
        rst = 1'b0;
        idle(4);
        rdTx(SCR_ADDR_CTRL, SCR_CTRL_RESET, SCR_FLAGS_RESET);
        $display("test midrun reset done");
        finish_test();
    end

    // Cuts a hang short
    initial begin
        idle(80000);
        check("timeout", 8'h00, 8'h01);
        finish_test();
    end
endmodule

// ---- tb/scr_master.sv ----
// Serial bus master model that drives the clock and data pins of the register block.
// Assumes a pull-up on the data line; every half phase lasts two ticks of four mclk.
`timescale 1ns/10ps
module scr_master (
    // Clock
    input wire logic mclk,
    // Serial pins
    input wire logic sdaOe,
    output logic sclIn,
    output logic sdaIn
);
    logic mstLow = 1'b0;
    initial sclIn = 1'b1;
    // Released line floats to the pull-up level
    assign sdaIn = ~(mstLow | sdaOe);

    task automatic tick;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    task automatic clkBit(input logic drv, output logic seen);
        tick;
        mstLow = ~drv;
        tick;
        sclIn = 1'b1;
        tick;
        seen = sdaIn;
        tick;
        sclIn = 1'b0;
    endtask

    task automatic start;
        tick;
        mstLow = 1'b1;
        tick;
        sclIn = 1'b0;
    endtask

    task automatic stop;
        tick;
        mstLow = 1'b1;
        tick;
        sclIn = 1'b1;
        tick;
        mstLow = 1'b0;
        tick;
        tick;
    endtask

    // Goes on with the next byte whatever the acknowledge slot held
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clkBit(b[i], s);
        clkBit(1'b1, s);
        ack = ~s;
    endtask

    task automatic recvByte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clkBit(1'b1, s);
            b[i] = s;
        end
        clkBit(last, s);
    endtask
endmodule
